// file: feature_value_mem.sv
`timescale 1ns/1ps
`default_nettype none
module feature_value_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  // Array carries no reset; the owner sweeps it after reset
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else if (i_clk_en && i_re) begin
      rdata_ff <= mem[i_raddr];
    end
  end

  assign o_rdata = rdata_ff;
endmodule : feature_value_mem
`default_nettype wire

// file: host_sf_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_sf_model (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [31:0] i_dw10,
  input wire logic [31:0] i_dw11,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_dw10,
  output logic [31:0] o_dw11
);
  initial {o_valid, o_dw10, o_dw11} = '0;
  // Request is held until taken, even through the table sweep
  always @(posedge i_sys_clk) begin
    if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_dw10 <= ~o_dw10;
      o_dw11 <= ~o_dw11;
    end else if (i_go && !o_valid) begin
      o_valid <= 1'b1;
      o_dw10 <= i_dw10;
      o_dw11 <= i_dw11;
    end
  end
endmodule : host_sf_model
`default_nettype wire

// file: ns_admin_pkg.sv
package ns_admin_pkg;
  // Status code types
  localparam logic [2:0] SCT_GENERIC = 3'h0;
  localparam logic [2:0] SCT_CMD_SPECIFIC = 3'h1;
  localparam logic [7:0] SC_SUCCESS = 8'h00;
  localparam logic [7:0] SC_INVALID_FORMAT = 8'h0A;
  localparam logic [7:0] SC_INSUFFICIENT_CAPACITY = 8'h15;
  localparam logic [7:0] SC_NAMESPACE_ID_UNAVAILABLE = 8'h16;
  localparam logic [7:0] SC_THIN_PROV_UNSUPPORTED = 8'h1B;
  // Namespace management select field
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_CREATE = 4'h0;
  localparam logic [3:0] SEL_DELETE = 4'h1;
  localparam logic [31:0] NAMESPACE_ID_ALL = 32'hFFFF_FFFF;
  // Set features dword 10 layout
  localparam int PERSIST_FLAG_BIT = 31;
  localparam int FEATURE_SELECTOR_LSB = 0;
  localparam int FEATURE_SELECTOR_W = 8;
  localparam int FEATURE_COUNT = 256;
  // Optional command support field
  localparam int OPT_CMD_SUPPORT_W = 16;
  localparam int OPT_CMD_PERSIST_BIT = 4;
  // Reset and init values
  localparam logic [31:0] FEATURE_INIT_VALUE = 32'h0000_0000;
  localparam logic [7:0] INIT_LAST_ENTRY = 8'hFF;
endpackage : ns_admin_pkg

// file: ns_mgmt_completion_set_features_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ns_mgmt_completion_set_features_decode #(
  parameter logic [7:0] SC_INVALID_FIELD = 8'h02,
  parameter logic [7:0] SC_FEATURE_NOT_SAVEABLE = 8'h0D,
  parameter logic [7:0] SC_FEATURE_NOT_CHANGEABLE = 8'h0E,
  parameter int FSEL_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Namespace management completion request
  input wire logic i_nsm_valid,
  input wire logic [3:0] i_nsm_sel,
  input wire logic [31:0] i_nsm_namespace_id,
  input wire logic i_fmt_bad_number,
  input wire logic i_fmt_prot_no_meta,
  input wire logic i_fmt_unavailable,
  input wire logic i_fmt_bad_security,
  input wire logic i_thin_requested,
  input wire logic i_thin_supported,
  input wire logic i_ns_count_full,
  input wire logic [63:0] i_required_bytes,
  input wire logic [63:0] i_free_bytes,
  input wire logic [31:0] i_new_namespace_id,
  output logic o_nsm_cpl_valid,
  output logic [2:0] o_nsm_cpl_sct,
  output logic [7:0] o_nsm_cpl_sc,
  output logic [31:0] o_nsm_cpl_dw0,
  output logic o_errlog_valid,
  output logic [63:0] o_errlog_info,
  // Set features request
  input wire logic i_sf_valid,
  output logic o_sf_ready,
  input wire logic [127:0] i_sf_data_buffer_pointer,
  input wire logic [31:0] i_sf_dw10,
  input wire logic [31:0] i_sf_dw11,
  input wire logic [31:0] i_sf_dw12,
  input wire logic [31:0] i_sf_dw13,
  input wire logic [31:0] i_sf_dw14,
  input wire logic [31:0] i_sf_dw15,
  input wire logic i_persist_supported,
  input wire logic [255:0] i_feat_supported_mask,
  input wire logic [255:0] i_feat_saveable_mask,
  input wire logic [255:0] i_feat_changeable_mask,
  input wire logic [255:0] i_feat_buffer_mask,
  output logic o_sf_cpl_valid,
  output logic [2:0] o_sf_cpl_sct,
  output logic [7:0] o_sf_cpl_sc,
  output logic o_feat_apply,
  output logic o_persist_write,
  output logic [FSEL_W-1:0] o_feature_selector,
  output logic [31:0] o_feat_dw11,
  output logic [31:0] o_feat_dw12,
  output logic [31:0] o_feat_dw13,
  output logic [31:0] o_feat_dw14,
  output logic [31:0] o_feat_dw15,
  output logic o_data_buffer_pointer_valid,
  output logic [127:0] o_data_buffer_pointer,
  output logic [15:0] o_opt_cmd_support
);
  logic nsm_cpl_valid_ff, nxt_nsm_cpl_valid;
  logic [2:0] nsm_sct_ff, nxt_nsm_sct;
  logic [7:0] nsm_sc_ff, nxt_nsm_sc;
  logic [31:0] nsm_dw0_ff, nxt_nsm_dw0;
  logic errlog_valid_ff, nxt_errlog_valid;
  logic [63:0] errlog_info_ff, nxt_errlog_info;
  logic fmt_bad;

  always_comb begin
    fmt_bad = i_fmt_bad_number | i_fmt_prot_no_meta |
              i_fmt_unavailable | i_fmt_bad_security;
    nxt_nsm_cpl_valid = i_nsm_valid;
    nxt_nsm_sct = ns_admin_pkg::SCT_GENERIC;
    nxt_nsm_sc = ns_admin_pkg::SC_SUCCESS;
    nxt_nsm_dw0 = '0;
    nxt_errlog_valid = 1'b0;
    nxt_errlog_info = errlog_info_ff;
    if (i_nsm_valid) begin
      case (i_nsm_sel)
        ns_admin_pkg::SEL_CREATE: begin
          // Format first, then thin, then id count, then capacity
          if (fmt_bad) begin
            nxt_nsm_sct = ns_admin_pkg::SCT_CMD_SPECIFIC;
            nxt_nsm_sc = ns_admin_pkg::SC_INVALID_FORMAT;
          end else if (i_thin_requested && !i_thin_supported) begin
            nxt_nsm_sct = ns_admin_pkg::SCT_CMD_SPECIFIC;
            nxt_nsm_sc = ns_admin_pkg::SC_THIN_PROV_UNSUPPORTED;
          end else if (i_ns_count_full) begin
            nxt_nsm_sct = ns_admin_pkg::SCT_CMD_SPECIFIC;
            nxt_nsm_sc = ns_admin_pkg::SC_NAMESPACE_ID_UNAVAILABLE;
          end else if (i_required_bytes > i_free_bytes) begin
            nxt_nsm_sct = ns_admin_pkg::SCT_CMD_SPECIFIC;
            nxt_nsm_sc = ns_admin_pkg::SC_INSUFFICIENT_CAPACITY;
            nxt_errlog_valid = 1'b1;
            nxt_errlog_info = i_required_bytes;
          end else begin
            nxt_nsm_dw0 = i_new_namespace_id;
          end
        end
        ns_admin_pkg::SEL_DELETE: begin
          // All-ones delete succeeds regardless of namespace count
          if (i_nsm_namespace_id == ns_admin_pkg::NAMESPACE_ID_ALL) begin
            nxt_nsm_sc = ns_admin_pkg::SC_SUCCESS;
          end
        end
        default: begin
          nxt_nsm_sc = SC_INVALID_FIELD;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      nsm_cpl_valid_ff <= 1'b0;
      nsm_sct_ff <= ns_admin_pkg::SCT_GENERIC;
      nsm_sc_ff <= ns_admin_pkg::SC_SUCCESS;
      nsm_dw0_ff <= '0;
      errlog_valid_ff <= 1'b0;
      errlog_info_ff <= '0;
    end else if (i_clk_en) begin
      nsm_cpl_valid_ff <= nxt_nsm_cpl_valid;
      nsm_sct_ff <= nxt_nsm_sct;
      nsm_sc_ff <= nxt_nsm_sc;
      nsm_dw0_ff <= nxt_nsm_dw0;
      errlog_valid_ff <= nxt_errlog_valid;
      errlog_info_ff <= nxt_errlog_info;
    end
  end

  typedef enum logic [1:0] {SF_INIT, SF_IDLE, SF_EVAL} sf_state_t;
  sf_state_t state_ff, nxt_state;
  logic [7:0] init_addr_ff, nxt_init_addr;
  logic ready_ff, nxt_ready;
  logic persist_ff, nxt_persist;
  logic [FSEL_W-1:0] fsel_ff, nxt_fsel;
  // Dwords 11 to 15, dword 11 in entry 0
  logic [4:0][31:0] dws_ff, nxt_dws;
  logic [127:0] data_buffer_pointer_ff, nxt_data_buffer_pointer;
  logic data_buffer_pointer_valid_ff, nxt_data_buffer_pointer_valid;
  logic sf_cpl_valid_ff, nxt_sf_cpl_valid;
  logic [2:0] sf_sct_ff, nxt_sf_sct;
  logic [7:0] sf_sc_ff, nxt_sf_sc;
  logic apply_ff, nxt_apply;
  logic persist_wr_ff, nxt_persist_wr;
  logic [15:0] opt_cmd_ff, nxt_opt_cmd;
  logic mem_we, mem_re;
  logic [7:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] cur_value;
  logic take;

  always_comb begin
    nxt_state = state_ff;
    nxt_init_addr = init_addr_ff;
    nxt_persist = persist_ff;
    nxt_fsel = fsel_ff;
    nxt_dws = dws_ff;
    nxt_data_buffer_pointer = data_buffer_pointer_ff;
    nxt_data_buffer_pointer_valid = data_buffer_pointer_valid_ff;
    nxt_sf_cpl_valid = 1'b0;
    nxt_sf_sct = sf_sct_ff;
    nxt_sf_sc = sf_sc_ff;
    nxt_apply = 1'b0;
    nxt_persist_wr = 1'b0;
    mem_we = 1'b0;
    mem_waddr = fsel_ff;
    mem_wdata = dws_ff[0];
    take = 1'b0;
    nxt_opt_cmd = '0;
    nxt_opt_cmd[ns_admin_pkg::OPT_CMD_PERSIST_BIT] =
      i_persist_supported;
    case (state_ff)
      SF_INIT: begin
        // Sweep the value table so every compare sees a defined value
        mem_we = 1'b1;
        mem_waddr = init_addr_ff;
        mem_wdata = ns_admin_pkg::FEATURE_INIT_VALUE;
        nxt_init_addr = init_addr_ff + 8'h01;
        if (init_addr_ff == ns_admin_pkg::INIT_LAST_ENTRY) begin
          nxt_state = SF_IDLE;
        end
      end
      SF_IDLE: begin
        if (i_sf_valid) begin
          take = 1'b1;
          // Only data_buffer_pointer and dwords 10..15 are captured; others unseen
          nxt_persist = i_sf_dw10[ns_admin_pkg::PERSIST_FLAG_BIT];
          nxt_fsel = i_sf_dw10[ns_admin_pkg::FEATURE_SELECTOR_LSB +:
                               FSEL_W];
          nxt_dws = {i_sf_dw15, i_sf_dw14, i_sf_dw13, i_sf_dw12, i_sf_dw11};
          nxt_data_buffer_pointer = i_sf_data_buffer_pointer;
          nxt_state = SF_EVAL;
        end
      end
      SF_EVAL: begin
        nxt_sf_cpl_valid = 1'b1;
        nxt_sf_sct = ns_admin_pkg::SCT_GENERIC;
        nxt_sf_sc = ns_admin_pkg::SC_SUCCESS;
        // Pointer taken as given; page-list use is the host's to avoid
        nxt_data_buffer_pointer_valid = i_feat_buffer_mask[fsel_ff];
        if (!i_feat_supported_mask[fsel_ff]) begin
          nxt_sf_sc = SC_INVALID_FIELD;
          nxt_data_buffer_pointer_valid = 1'b0;
        end else if (persist_ff && !(i_persist_supported &&
                     i_feat_saveable_mask[fsel_ff])) begin
          nxt_sf_sct = ns_admin_pkg::SCT_CMD_SPECIFIC;
          nxt_sf_sc = SC_FEATURE_NOT_SAVEABLE;
          nxt_data_buffer_pointer_valid = 1'b0;
        end else if (!i_feat_changeable_mask[fsel_ff] &&
                     (dws_ff[0] != cur_value)) begin
          nxt_sf_sct = ns_admin_pkg::SCT_CMD_SPECIFIC;
          nxt_sf_sc = SC_FEATURE_NOT_CHANGEABLE;
          nxt_data_buffer_pointer_valid = 1'b0;
        end else begin
          // Table updated before the next accept can read it
          mem_we = 1'b1;
          nxt_apply = 1'b1;
          nxt_persist_wr = persist_ff;
        end
        nxt_state = SF_IDLE;
      end
      default: begin
        nxt_state = SF_INIT;
      end
    endcase
    mem_re = take;
    nxt_ready = (nxt_state == SF_IDLE);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_ff <= SF_INIT;
      init_addr_ff <= '0;
      ready_ff <= 1'b0;
      persist_ff <= 1'b0;
      fsel_ff <= '0;
      dws_ff <= '0;
      data_buffer_pointer_ff <= '0;
      data_buffer_pointer_valid_ff <= 1'b0;
      sf_cpl_valid_ff <= 1'b0;
      sf_sct_ff <= ns_admin_pkg::SCT_GENERIC;
      sf_sc_ff <= ns_admin_pkg::SC_SUCCESS;
      apply_ff <= 1'b0;
      persist_wr_ff <= 1'b0;
      opt_cmd_ff <= '0;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
      init_addr_ff <= nxt_init_addr;
      ready_ff <= nxt_ready;
      persist_ff <= nxt_persist;
      fsel_ff <= nxt_fsel;
      dws_ff <= nxt_dws;
      data_buffer_pointer_ff <= nxt_data_buffer_pointer;
      data_buffer_pointer_valid_ff <= nxt_data_buffer_pointer_valid;
      sf_cpl_valid_ff <= nxt_sf_cpl_valid;
      sf_sct_ff <= nxt_sf_sct;
      sf_sc_ff <= nxt_sf_sc;
      apply_ff <= nxt_apply;
      persist_wr_ff <= nxt_persist_wr;
      opt_cmd_ff <= nxt_opt_cmd;
    end
  end

  feature_value_mem #(.AW(FSEL_W), .DW(32)) u_value_mem (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_we(mem_we), .i_waddr(mem_waddr), .i_wdata(mem_wdata),
    .i_re(mem_re),
    .i_raddr(i_sf_dw10[ns_admin_pkg::FEATURE_SELECTOR_LSB +: FSEL_W]),
    .o_rdata(cur_value)
  );

  assign o_nsm_cpl_valid = nsm_cpl_valid_ff;
  assign o_nsm_cpl_sct = nsm_sct_ff;
  assign o_nsm_cpl_sc = nsm_sc_ff;
  assign o_nsm_cpl_dw0 = nsm_dw0_ff;
  assign o_errlog_valid = errlog_valid_ff;
  assign o_errlog_info = errlog_info_ff;
  assign o_sf_ready = ready_ff;
  assign o_sf_cpl_valid = sf_cpl_valid_ff;
  assign o_sf_cpl_sct = sf_sct_ff;
  assign o_sf_cpl_sc = sf_sc_ff;
  assign o_feat_apply = apply_ff;
  assign o_persist_write = persist_wr_ff;
  assign o_feature_selector = fsel_ff;
  assign {o_feat_dw15, o_feat_dw14, o_feat_dw13, o_feat_dw12, o_feat_dw11} =
    dws_ff;
  assign o_data_buffer_pointer_valid = data_buffer_pointer_valid_ff;
  assign o_data_buffer_pointer = data_buffer_pointer_ff;
  assign o_opt_cmd_support = opt_cmd_ff;
endmodule : ns_mgmt_completion_set_features_decode
`default_nettype wire

// file: ns_mgmt_completion_set_features_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module ns_mgmt_completion_set_features_decode_test;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_clk_en = 1'b1, go = 1'b0;
  logic i_nsm_valid = 1'b0, i_thin_requested = 1'b0;
  logic i_thin_supported = 1'b0, i_ns_count_full = 1'b0;
  logic i_fmt_bad_number = 1'b0, i_fmt_prot_no_meta = 1'b0;
  logic i_fmt_unavailable = 1'b0, i_fmt_bad_security = 1'b0;
  logic i_persist_supported = 1'b0, i_sf_valid;
  logic [3:0] i_nsm_sel = 4'h0;
  logic [31:0] i_nsm_namespace_id = '0, i_new_namespace_id = '0;
  logic [31:0] d10 = '0, d11 = '0, i_sf_dw10, i_sf_dw11;
  logic [31:0] i_sf_dw12 = '0, i_sf_dw13 = '0, i_sf_dw14 = '0, i_sf_dw15 = '0;
  logic [63:0] i_required_bytes = '0, i_free_bytes = '0, o_errlog_info;
  logic [127:0] i_sf_data_buffer_pointer = '0, o_data_buffer_pointer;
  logic [255:0] i_feat_supported_mask = '0, i_feat_saveable_mask = '0;
  logic [255:0] i_feat_changeable_mask = '0, i_feat_buffer_mask = '0;
  logic o_nsm_cpl_valid, o_errlog_valid, o_sf_ready, o_sf_cpl_valid;
  logic o_feat_apply, o_persist_write, o_data_buffer_pointer_valid;
  logic [2:0] o_nsm_cpl_sct, o_sf_cpl_sct;
  logic [7:0] o_nsm_cpl_sc, o_sf_cpl_sc, o_feature_selector;
  logic [31:0] o_nsm_cpl_dw0, o_feat_dw11, o_feat_dw12, o_feat_dw13;
  logic [31:0] o_feat_dw14, o_feat_dw15, seed = 32'h0000_05f3, tbl [256];
  logic [15:0] o_opt_cmd_support;
  int fails = 0, checks = 0, cyc = 0;
  ns_mgmt_completion_set_features_decode
    i_ns_mgmt_completion_set_features_decode (.*);
  host_sf_model i_host_sf_model (.i_sys_clk(i_sys_clk), .i_go(go),
    .i_dw10(d10), .i_dw11(d11), .i_ready(o_sf_ready), .o_valid(i_sf_valid),
    .o_dw10(i_sf_dw10), .o_dw11(i_sf_dw11));
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string n, input logic [127:0] e, s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // Packed as {error log pulse, status type, status code}
  function automatic logic [11:0] nsm_exp();
    if (i_nsm_sel == ns_admin_pkg::SEL_DELETE) return 12'h000;
    if (i_nsm_sel != ns_admin_pkg::SEL_CREATE) return 12'h002;
    if (i_fmt_bad_number | i_fmt_prot_no_meta | i_fmt_unavailable
      | i_fmt_bad_security) return 12'h10A;
    if (i_thin_requested && !i_thin_supported) return 12'h11B;
    if (i_ns_count_full) return 12'h116;
    if (i_required_bytes > i_free_bytes) return 12'h915;
    return 12'h000;
  endfunction : nsm_exp
  task automatic nsm_run();
    logic [31:0] r;
    logic [11:0] e;
    logic [31:0] d;
    for (int k = 0; k < 300; k++) begin
      r = xs();
      i_nsm_valid = r[31] | r[30];
      i_nsm_sel = (r[3:0] > 4'hB) ? r[3:0] : {3'h0, r[4]};
      {i_fmt_bad_number, i_fmt_prot_no_meta, i_fmt_unavailable,
        i_fmt_bad_security} = r[11:8] & r[15:12] & r[19:16];
      {i_thin_requested, i_thin_supported} = r[21:20];
      i_ns_count_full = r[22] & r[23];
      i_nsm_namespace_id = r[24] ? 32'hFFFF_FFFF : xs();
      i_new_namespace_id = xs();
      i_required_bytes = {32'h0000_0000, xs()};
      i_free_bytes = (k % 16 == 5) ? i_required_bytes : {32'h0000_0000, xs()};
      @(negedge i_sys_clk);
      e = nsm_exp();
      chk("nsm valid", i_nsm_valid, o_nsm_cpl_valid);
      if (i_nsm_valid) begin
        chk("nsm status", e,
          {o_errlog_valid, o_nsm_cpl_sct, o_nsm_cpl_sc});
        d = (e == 0 && i_nsm_sel == ns_admin_pkg::SEL_CREATE) ?
          i_new_namespace_id : 32'h0000_0000;
        chk("nsm dw0", d, o_nsm_cpl_dw0);
        if (e[11]) chk("errlog", i_required_bytes, o_errlog_info);
      end
    end
    i_nsm_valid = 1'b0;
  endtask : nsm_run
  task automatic sf_cmd();
    logic [31:0] r;
    logic [10:0] e;
    logic [7:0] s;
    r = xs();
    s = r[9] ? {4'h0, r[3:0]} : r[7:0];
    repeat (r[13:12]) @(negedge i_sys_clk);
    d10 = {r[31:8], s};
    d11 = r[10] ? tbl[s] : xs();
    i_persist_supported = r[11];
    {i_sf_dw12, i_sf_dw13, i_sf_dw14, i_sf_dw15} = {xs(), xs(), xs(), xs()};
    i_sf_data_buffer_pointer = {xs(), xs(), xs(), xs()};
    go = 1'b1;
    @(negedge i_sys_clk);
    go = 1'b0;
    for (int i = 0; i < 400 && o_sf_cpl_valid !== 1'b1; i++) begin
      @(negedge i_sys_clk);
    end
    e = 11'h000;
    if (!i_feat_supported_mask[s]) e = 11'h002;
    else if (d10[31] && !(i_persist_supported && i_feat_saveable_mask[s]))
      e = 11'h10D;
    else if (!i_feat_changeable_mask[s] && d11 != tbl[s])
      e = 11'h10E;
    chk("sf cpl", 1'b1, o_sf_cpl_valid);
    chk("sf status", e, {o_sf_cpl_sct, o_sf_cpl_sc});
    chk("sf pulses",
      {e == 0, e == 0 && d10[31], e == 0 && i_feat_buffer_mask[s]},
      {o_feat_apply, o_persist_write, o_data_buffer_pointer_valid});
    chk("sf sel", {s, d11}, {o_feature_selector, o_feat_dw11});
    chk("sf dw", {i_sf_dw12, i_sf_dw13, i_sf_dw14, i_sf_dw15},
      {o_feat_dw12, o_feat_dw13, o_feat_dw14, o_feat_dw15});
    chk("opt", {11'h000, i_persist_supported, 4'h0},
      o_opt_cmd_support);
    if (e == 0 && i_feat_buffer_mask[s])
      chk("data_buffer_pointer", i_sf_data_buffer_pointer, o_data_buffer_pointer);
    if (e == 0) tbl[s] = d11;
  endtask : sf_cmd
  initial begin
    for (int i = 0; i < 256; i++) tbl[i] = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      i_feat_supported_mask[i*32 +: 32] = xs() | xs();
      i_feat_saveable_mask[i*32 +: 32] = xs();
      i_feat_changeable_mask[i*32 +: 32] = xs();
      i_feat_buffer_mask[i*32 +: 32] = xs();
    end
    repeat (6) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    // First request lands during the table sweep and must wait for ready
    fork
      nsm_run();
      repeat (150) sf_cmd();
    join
    // Clock enable low must hold back a finished command until it rises
    @(negedge i_sys_clk);
    i_clk_en = 1'b0;
    i_nsm_valid = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk("frozen cpl", 1'b0, o_nsm_cpl_valid);
    i_clk_en = 1'b1;
    @(negedge i_sys_clk);
    i_nsm_valid = 1'b0;
    chk("thawed cpl", 1'b1, o_nsm_cpl_valid);
    @(negedge i_sys_clk);
    chk("cpl pulse end", 1'b0, o_nsm_cpl_valid);
    test_done();
  end
endmodule : ns_mgmt_completion_set_features_decode_test
`default_nettype wire

// file: ns_mgmt_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ns_mgmt_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_nsm_valid,
  input wire logic [3:0] i_nsm_sel,
  input wire logic i_fmt_bad_number,
  input wire logic i_fmt_prot_no_meta,
  input wire logic i_fmt_unavailable,
  input wire logic i_fmt_bad_security,
  input wire logic i_thin_requested,
  input wire logic i_thin_supported,
  input wire logic i_ns_count_full,
  input wire logic [63:0] i_required_bytes,
  input wire logic [63:0] i_free_bytes,
  input wire logic [31:0] i_new_namespace_id,
  input wire logic o_nsm_cpl_valid,
  input wire logic [7:0] o_nsm_cpl_sc,
  input wire logic [31:0] o_nsm_cpl_dw0,
  input wire logic o_errlog_valid,
  input wire logic [63:0] o_errlog_info,
  input wire logic i_sf_valid,
  input wire logic o_sf_ready,
  input wire logic [31:0] i_sf_dw10,
  input wire logic i_persist_supported,
  input wire logic [255:0] i_feat_supported_mask,
  input wire logic o_sf_cpl_valid,
  input wire logic [7:0] o_sf_cpl_sc,
  input wire logic o_persist_write
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic nv, cr, dl, f0, f1, f2, cap, sv_bad;
  assign nv = i_clk_en && i_nsm_valid;
  assign cr = nv && i_nsm_sel == ns_admin_pkg::SEL_CREATE;
  assign dl = nv && i_nsm_sel == ns_admin_pkg::SEL_DELETE;
  assign f0 = cr && !(i_fmt_bad_number || i_fmt_prot_no_meta
    || i_fmt_unavailable || i_fmt_bad_security);
  assign f1 = f0 && !(i_thin_requested && !i_thin_supported);
  assign f2 = f1 && !i_ns_count_full;
  assign cap = i_required_bytes > i_free_bytes;
  assign sv_bad = i_sf_dw10[31] && !i_persist_supported
    && i_feat_supported_mask[i_sf_dw10[7:0]];
  sequence s_take;
    i_clk_en && i_sf_valid && o_sf_ready;
  endsequence
  sequence s_answer;
    !o_sf_ready ##1 (o_sf_cpl_valid && o_sf_ready);
  endsequence
  a_nsm_cpl_pulse: assert property (nv |=> o_nsm_cpl_valid)
    else $error("namespace completion missing");
  a_fmt_status: assert property (cr && !f0 |=> o_nsm_cpl_sc == 8'h0A)
    else $error("format failure code wrong");
  a_id_full: assert property (f1 && !f2 |=> o_nsm_cpl_sc == 8'h16)
    else $error("identifier exhaustion code wrong");
  a_cap_log: assert property (f2 && cap |=> o_nsm_cpl_sc == 8'h15
    && o_errlog_valid && o_errlog_info == $past(i_required_bytes))
    else $error("capacity failure not logged");
  a_create_id: assert property (f2 && !cap |=> o_nsm_cpl_sc == 8'h00
    && o_nsm_cpl_dw0 == $past(i_new_namespace_id))
    else $error("created identifier wrong");
  a_delete_ok: assert property (dl |=> o_nsm_cpl_sc == 8'h00
    && o_nsm_cpl_dw0 == 32'h0000_0000)
    else $error("delete not successful");
  a_sf_latency: assert property (s_take |=> s_answer)
    else $error("set features answer late");
  a_not_saveable: assert property (s_take ##0 sv_bad |-> ##2
    o_sf_cpl_sc == 8'h0D && !o_persist_write)
    else $error("persist request not refused");
endmodule : ns_mgmt_chk
bind ns_mgmt_completion_set_features_decode ns_mgmt_chk i_ns_mgmt_chk (.*);
`default_nettype wire
